/* rtl/sdrs_controller.sv */
// controller end: power-up init and self-refresh entry/exit sequencing
`timescale 1ns/100ps
`default_nettype none
`include "sdrs_defs.svh"
module sdrs_controller import sdrs_pkg::*; #(
  parameter int POWERUP_CYCLES = `SDRS_POWERUP_CYCLES,
  parameter int EXIT_PULSE_CYCLES = `SDRS_EXIT_PULSE_DEFAULT,
  parameter int CLK_SETTLE_CYCLES = 4,
  parameter int BURST_REFRESHES = `SDRS_BURST_REFRESHES
) (
  input wire logic clk,
  input wire logic rst,
  sdrs_if.ctl pins,
  input wire logic selfRefreshReq,
  input wire logic burstRefreshEn,
  output logic ready,
  output logic inSelfRefresh
);
  typedef struct packed {
    sdrs_ctl_state_t st;
    logic [15:0] cnt;
    logic [11:0] refs;
    logic [3:0] cmd;
    logic cke;
    logic clkRun;
    logic mask;
    logic a10;
    logic [12:0] addr;
  } sdrs_ctl_reg_t;
  sdrs_ctl_reg_t r, next_r;

  // -----------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.cmd = `SDRS_CMD_NOP;
    next_r.a10 = 1'b0;
    next_r.addr = 13'h0000;
    if (r.cnt != 16'h0000) begin
      next_r.cnt = r.cnt - 16'h0001;
    end
    case (r.st)
      CT_POWERUP: begin
        next_r.mask = 1'b1;
        if (r.cnt == 16'h0000) begin
          next_r.st = CT_PRECHARGE;
        end
      end
      CT_PRECHARGE: begin
        next_r.cmd = `SDRS_CMD_PRECHARGE;
        next_r.a10 = 1'b1;
        next_r.st = CT_TRP;
        next_r.cnt = 16'(`SDRS_PRECHARGE_CYCLES);
      end
      CT_TRP: begin
        if (r.cnt == 16'h0000) begin
          next_r.st = CT_MODE;
        end
      end
      CT_MODE: begin
        next_r.cmd = `SDRS_CMD_MODE_SET;
        next_r.addr = `SDRS_MODE_VALUE;
        next_r.st = CT_MRD;
        next_r.cnt = 16'(`SDRS_MODE_SET_GAP);
        next_r.refs = 12'h000;
      end
      CT_MRD: begin
        if (r.cnt == 16'h0000) begin
          next_r.st = CT_REFRESH;
        end
      end
      CT_REFRESH: begin
        next_r.cmd = `SDRS_CMD_REFRESH;
        next_r.refs = r.refs + 12'h001;
        next_r.st = CT_TRC;
        next_r.cnt = 16'(`SDRS_ROW_CYCLE_CYCLES);
      end
      CT_TRC: begin
        if (r.cnt == 16'h0000) begin
          next_r.st = (r.refs >= 12'(`SDRS_INIT_REFRESHES)) ? CT_READY : CT_REFRESH;
        end
      end
      CT_READY: begin
        next_r.mask = 1'b0;
        if (selfRefreshReq) begin
          next_r.refs = 12'h000;
          next_r.st = burstRefreshEn ? CT_PRE_SR : CT_SR_ENTER;
        end
      end
      CT_PRE_SR: begin
        next_r.cmd = `SDRS_CMD_REFRESH;
        next_r.refs = r.refs + 12'h001;
        next_r.cnt = 16'(`SDRS_ROW_CYCLE_CYCLES);
        next_r.st = CT_PRE_SR_WAIT;
      end
      CT_PRE_SR_WAIT: begin
        if (r.cnt == 16'h0000) begin
          next_r.st = (r.refs == 12'(BURST_REFRESHES)) ? CT_SR_ENTER : CT_PRE_SR;
        end
      end
      CT_SR_ENTER: begin
        next_r.cmd = `SDRS_CMD_REFRESH;
        next_r.cke = 1'b0;
        next_r.cnt = 16'(`SDRS_MIN_ACTIVE_CYCLES);
        next_r.st = CT_SR_HOLD;
      end
      CT_SR_HOLD: begin
        next_r.clkRun = 1'b0;
        if (r.cnt == 16'h0000 && !selfRefreshReq) begin
          next_r.clkRun = 1'b1;
          next_r.cnt = 16'(CLK_SETTLE_CYCLES);
          next_r.st = CT_CLK_WAKE;
        end
      end
      CT_CLK_WAKE: begin
        if (r.cnt == 16'h0000) begin
          next_r.cke = 1'b1;
          next_r.cmd = `SDRS_CMD_DESELECT;
          next_r.cnt = 16'(EXIT_PULSE_CYCLES);
          next_r.st = CT_EXIT_PULSE;
        end
      end
      CT_EXIT_PULSE: begin
        next_r.cmd = `SDRS_CMD_DESELECT;
        if (r.cnt == 16'h0000) begin
          next_r.cnt = 16'(`SDRS_ROW_CYCLE_CYCLES);
          next_r.st = CT_EXIT_WAIT;
        end
      end
      CT_EXIT_WAIT: begin
        if (r.cnt == 16'h0000) begin
          next_r.refs = 12'h000;
          next_r.st = burstRefreshEn ? CT_POST_SR : CT_READY;
        end
      end
      CT_POST_SR: begin
        next_r.cmd = `SDRS_CMD_REFRESH;
        next_r.refs = r.refs + 12'h001;
        next_r.cnt = 16'(`SDRS_ROW_CYCLE_CYCLES);
        next_r.st = CT_POST_SR_WAIT;
      end
      CT_POST_SR_WAIT: begin
        if (r.cnt == 16'h0000) begin
          next_r.st = (r.refs == 12'(BURST_REFRESHES)) ? CT_READY : CT_POST_SR;
        end
      end
      default: begin
        next_r.st = CT_POWERUP;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // state register; reset starts with nop, gate and mask high
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{st: CT_POWERUP, cnt: 16'(POWERUP_CYCLES), refs: 12'h000, cmd: `SDRS_CMD_NOP, cke: 1'b1,
        clkRun: 1'b1, mask: 1'b1, a10: 1'b0, addr: 13'h0000};
    end else begin
      r <= next_r;
    end
  end

  // -----------------------------------------------------------------
  // pin drive
  // -----------------------------------------------------------------
  assign pins.selectN = r.cmd[3];
  assign pins.rowStrobeN = r.cmd[2];
  assign pins.columnStrobeN = r.cmd[1];
  assign pins.writeStrobeN = r.cmd[0];
  assign pins.clkGateInput = r.cke;
  assign pins.clkRun = r.clkRun;
  assign pins.byteMaskInput = {4{r.mask}};
  assign pins.addr = r.addr | (r.a10 ? 13'h0400 : 13'h0000);
  assign pins.bank = 2'h0;
  assign ready = (r.st == CT_READY);
  assign inSelfRefresh = (r.st == CT_SR_HOLD);
endmodule // sdrs_controller
`default_nettype wire

/* rtl/sdrs_defs.svh */
// timing counts and command encodings for the init/self-refresh sequencer
`ifndef SDRS_DEFS_SVH
`define SDRS_DEFS_SVH
`define SDRS_CLK_PERIOD_NS 20
`define SDRS_POWERUP_WAIT_US 200
`define SDRS_POWERUP_CYCLES ((`SDRS_POWERUP_WAIT_US * 1000 + `SDRS_CLK_PERIOD_NS - 1) / `SDRS_CLK_PERIOD_NS)
`define SDRS_ROW_CYCLE_NS 70
`define SDRS_ROW_CYCLE_CYCLES ((`SDRS_ROW_CYCLE_NS + `SDRS_CLK_PERIOD_NS - 1) / `SDRS_CLK_PERIOD_NS)
`define SDRS_MIN_ACTIVE_NS 42
`define SDRS_MIN_ACTIVE_CYCLES ((`SDRS_MIN_ACTIVE_NS + `SDRS_CLK_PERIOD_NS - 1) / `SDRS_CLK_PERIOD_NS)
`define SDRS_PRECHARGE_NS 20
`define SDRS_PRECHARGE_CYCLES ((`SDRS_PRECHARGE_NS + `SDRS_CLK_PERIOD_NS - 1) / `SDRS_CLK_PERIOD_NS)
`define SDRS_MODE_SET_GAP 2
`define SDRS_EXIT_PULSE_DEFAULT 2
`define SDRS_INIT_REFRESHES 2
`define SDRS_BURST_REFRESHES 2048
`define SDRS_MODE_VALUE 13'h0020
// command pins {select_n, row_strobe_n, column_strobe_n, write_strobe_n}
`define SDRS_CMD_NOP 4'h7
`define SDRS_CMD_PRECHARGE 4'h2
`define SDRS_CMD_REFRESH 4'h1
`define SDRS_CMD_MODE_SET 4'h0
`define SDRS_CMD_DESELECT 4'hf
`define SDRS_A10_ALL_BANKS 10
`endif

/* rtl/sdrs_pkg.sv */
// types shared by the controller and device ends
`default_nettype none
package sdrs_pkg;
  typedef enum {
    CT_POWERUP, CT_PRECHARGE, CT_TRP, CT_MODE, CT_MRD, CT_REFRESH, CT_TRC, CT_READY,
    CT_PRE_SR, CT_PRE_SR_WAIT, CT_SR_ENTER, CT_SR_HOLD, CT_CLK_WAKE, CT_EXIT_PULSE, CT_EXIT_WAIT,
    CT_POST_SR, CT_POST_SR_WAIT
  } sdrs_ctl_state_t;
  typedef enum {DV_UNINIT, DV_ACTIVE, DV_SELFREF} sdrs_dev_state_t;
endpackage
`default_nettype wire

/* rtl/sdrs_if.sv */
// command pins between controller and memory device
`timescale 1ns/100ps
`default_nettype none
interface sdrs_if;
  logic clkRun;
  logic clkGateInput;
  logic selectN;
  logic rowStrobeN;
  logic columnStrobeN;
  logic writeStrobeN;
  logic [3:0] byteMaskInput;
  logic [12:0] addr;
  logic [1:0] bank;
  modport ctl (output clkRun, output clkGateInput, output selectN, output rowStrobeN, output columnStrobeN,
    output writeStrobeN, output byteMaskInput, output addr, output bank);
  modport dev (input clkRun, input clkGateInput, input selectN, input rowStrobeN, input columnStrobeN,
    input writeStrobeN, input byteMaskInput, input addr, input bank);
endinterface
`default_nettype wire

/* rtl/sdrs_device.sv */
// device end: init tracking, self-refresh and clock suspension
`timescale 1ns/100ps
`default_nettype none
`include "sdrs_defs.svh"
module sdrs_device import sdrs_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  sdrs_if.dev pins,
  output logic inSelfRefresh,
  output logic clockFrozen,
  output logic initDone,
  output logic [1:0] refreshCount,
  output logic [12:0] modeValue
);
  typedef struct packed {
    sdrs_dev_state_t st;
    logic cke;
    logic frozen;
    logic modeSeen;
    logic [1:0] refs;
    logic [12:0] mode;
  } sdrs_dev_reg_t;
  sdrs_dev_reg_t r, next_r;
  logic [3:0] cmd;
  assign cmd = {pins.selectN, pins.rowStrobeN, pins.columnStrobeN, pins.writeStrobeN};

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.cke = pins.clkGateInput;
    next_r.frozen = !r.cke;
    case (r.st)
      DV_SELFREF: begin
        // gate is low here, so the suspension flag stays set until one cycle after the gate returns
        if (pins.clkGateInput) begin
          next_r.st = DV_ACTIVE;
        end
      end
      default: begin
        if (r.cke && !pins.clkGateInput && cmd[3:1] == 3'h0) begin
          next_r.st = DV_SELFREF;
        end else if (r.cke && pins.clkGateInput && !r.frozen) begin
          if (cmd == `SDRS_CMD_MODE_SET) begin
            next_r.mode = pins.addr;
            next_r.modeSeen = 1'b1;
          end else if (cmd == `SDRS_CMD_REFRESH && r.modeSeen && r.refs != 2'h3) begin
            next_r.refs = r.refs + 2'h1;
          end
          if (r.modeSeen && r.refs >= 2'(`SDRS_INIT_REFRESHES)) begin
            next_r.st = DV_ACTIVE;
          end
        end
      end
    endcase
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= '{st: DV_UNINIT, cke: 1'b1, frozen: 1'b0, modeSeen: 1'b0, refs: 2'h0, mode: 13'h0000};
    end else begin
      r <= next_r;
    end
  end

  assign inSelfRefresh = (r.st == DV_SELFREF);
  assign clockFrozen = r.frozen;
  assign initDone = (r.st != DV_UNINIT);
  assign refreshCount = r.refs;
  assign modeValue = r.mode;
endmodule // sdrs_device
`default_nettype wire

/* sim/sdrs_props.sv */
// assertions on the pins between controller and device
`timescale 1ns/100ps
`default_nettype none
`include "sdrs_defs.svh"
module sdrs_props #(
  parameter int POWERUP_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkRun,
  input wire logic clkGateInput,
  input wire logic selectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeStrobeN,
  input wire logic [3:0] byteMaskInput,
  input wire logic [12:0] addr,
  input wire logic [1:0] bank
);
  logic [3:0] cmd;
  logic quiet, isRef, isEntry, prechDone;
  logic [1:0] refCnt;
  int cyc;
  // command decode
  assign cmd = {selectN, rowStrobeN, columnStrobeN, writeStrobeN};
  assign quiet = selectN || cmd == `SDRS_CMD_NOP;
  assign isRef = cmd == `SDRS_CMD_REFRESH && clkGateInput;
  assign isEntry = !selectN && !rowStrobeN && !columnStrobeN && !clkGateInput;
  // cycles since reset, precharge seen, refreshes seen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc <= 0;
      prechDone <= 1'h0;
      refCnt <= 2'h0;
    end else begin
      cyc <= cyc + 1;
      if (cmd == `SDRS_CMD_PRECHARGE) prechDone <= 1'h1;
      if (isRef && refCnt != 2'h2) refCnt <= refCnt + 2'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_pulse;
    (clkGateInput && selectN) [*2];
  endsequence
  sequence s_settle;
    quiet [*4];
  endsequence
  property p_idle;
    !prechDone && cmd != `SDRS_CMD_PRECHARGE |-> cmd == `SDRS_CMD_NOP && clkGateInput && byteMaskInput == 4'hf;
  endproperty
  property p_wait;
    !prechDone && cmd == `SDRS_CMD_PRECHARGE |-> cyc >= POWERUP_CYCLES;
  endproperty
  property p_all;
    cmd == `SDRS_CMD_PRECHARGE |-> addr[10];
  endproperty
  property p_gap;
    cmd == `SDRS_CMD_MODE_SET |=> quiet;
  endproperty
  property p_spacing;
    isRef |=> quiet [*3];
  endproperty
  property p_entry;
    isEntry |-> writeStrobeN && refCnt == 2'h2;
  endproperty
  property p_hold;
    isEntry |-> !clkGateInput [*3];
  endproperty
  property p_wake;
    $rose(clkGateInput) |-> $past(clkRun) && $past(clkRun, 2);
  endproperty
  property p_exit;
    $rose(clkGateInput) |-> s_pulse and s_settle;
  endproperty
  a_idle: assert property (p_idle) else $error("pins busy in wait");
  a_wait: assert property (p_wait) else $error("early precharge");
  a_all: assert property (p_all) else $error("not all banks");
  a_gap: assert property (p_gap) else $error("mode gap short");
  a_spacing: assert property (p_spacing) else $error("refresh too close");
  a_entry: assert property (p_entry) else $error("bad entry");
  a_hold: assert property (p_hold) else $error("exit too soon");
  a_wake: assert property (p_wake) else $error("gate before clock");
  a_exit: assert property (p_exit) else $error("bad exit");
endmodule // sdrs_props
`default_nettype wire

/* sim/sdrs_init_selfrefresh_seq_bench.sv */
// bench joining controller and device ends
`timescale 1ns/100ps
`default_nettype none
`include "sdrs_defs.svh"
module sdrs_init_selfrefresh_seq_bench;
  localparam int PU = 20;
  localparam int BR = 4;
  logic clk, rst, srReq, burstEn, ctlReady, ctlInSr, devInSr, devFrozen, devInit;
  logic [1:0] devRefs;
  logic [12:0] devMode;
  logic [3:0] pinCmd;
  int n_errors = 0;
  int checks = 0;
  int q[$];
  int e[$];
  sdrs_if link();
  sdrs_controller #(.POWERUP_CYCLES(PU), .BURST_REFRESHES(BR)) sdrs_controller_i (.clk(clk), .rst(rst),
    .pins(link.ctl), .selfRefreshReq(srReq), .burstRefreshEn(burstEn), .ready(ctlReady), .inSelfRefresh(ctlInSr));
  sdrs_device sdrs_device_i (.clk(clk), .rst(rst), .pins(link.dev), .inSelfRefresh(devInSr),
    .clockFrozen(devFrozen), .initDone(devInit), .refreshCount(devRefs), .modeValue(devMode));
  sdrs_props #(.POWERUP_CYCLES(PU)) sdrs_props_i (.clk(clk), .rst(rst), .clkRun(link.clkRun),
    .clkGateInput(link.clkGateInput), .selectN(link.selectN), .rowStrobeN(link.rowStrobeN),
    .columnStrobeN(link.columnStrobeN), .writeStrobeN(link.writeStrobeN),
    .byteMaskInput(link.byteMaskInput), .addr(link.addr), .bank(link.bank));
  // clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // log each selected command other than nop as gate*16 + command
  assign pinCmd = {link.selectN, link.rowStrobeN, link.columnStrobeN, link.writeStrobeN};
  always @(posedge clk) begin
    if (!rst && !link.selectN && pinCmd != `SDRS_CMD_NOP) q.push_back(int'({link.clkGateInput, pinCmd}));
  end
  // value compare
  task chk_val(string what, logic [12:0] got, logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // command list compare against the model list
  task chk_cmds(string what);
    chk_val(what, 13'(q.size()), 13'(e.size()));
    foreach (e[i]) if (i < q.size()) chk_val(what, 13'(q[i]), 13'(e[i]));
    q.delete();
    e.delete();
  endtask
  // bounded wait for a level
  task automatic wait_lvl(string what, ref logic sig, input logic lvl);
    for (int k = 0; k < 300 && sig !== lvl; k++) @(negedge clk);
    chk_val(what, 13'(sig), 13'(lvl));
  endtask
  // reset, then precharge, mode set and the init refreshes
  task do_init();
    rst = 1'h1;
    repeat (16) @(negedge clk);
    q.delete();
    rst = 1'h0;
    e = '{16 + `SDRS_CMD_PRECHARGE, 16 + `SDRS_CMD_MODE_SET};
    repeat (`SDRS_INIT_REFRESHES) e.push_back(16 + `SDRS_CMD_REFRESH);
    wait_lvl("ready", ctlReady, 1'h1);
    chk_cmds("init");
    chk_val("done", 13'(devInit), 13'h1);
    chk_val("refs", 13'(devRefs), 13'h2);
    chk_val("mode", devMode, `SDRS_MODE_VALUE);
    $display("init test ends at %0t", $time);
  endtask
  // one self-refresh entry, stay and exit
  task sr_test(logic burst, int hold);
    @(negedge clk);
    burstEn = burst;
    srReq = 1'h1;
    repeat (burst ? BR : 0) e.push_back(16 + `SDRS_CMD_REFRESH);
    e.push_back(`SDRS_CMD_REFRESH);
    wait_lvl("dev sr", devInSr, 1'h1);
    chk_cmds("entry");
    repeat (hold) @(negedge clk);
    chk_val("frozen", 13'(devFrozen), 13'h1);
    chk_val("stays", 13'(devInSr), 13'h1);
    chk_val("ctl sr", 13'(ctlInSr), 13'h1);
    srReq = 1'h0;
    repeat (burst ? BR : 0) e.push_back(16 + `SDRS_CMD_REFRESH);
    wait_lvl("ready", ctlReady, 1'h1);
    chk_cmds("exit");
    chk_val("dev out", 13'(devInSr), 13'h0);
    chk_val("thawed", 13'(devFrozen), 13'h0);
    $display("sr test burst %0d hold %0d ends", burst, hold);
  endtask
  // print counts and verdict
  task close_out();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence, ending with a reset in mid self-refresh
  initial begin
    srReq = 1'h0;
    burstEn = 1'h0;
    void'($urandom(32'ha1318033));
    do_init();
    for (int i = 0; i < 4; i++) sr_test(i[0], 3 + $urandom_range(12));
    @(negedge clk);
    srReq = 1'h1;
    wait_lvl("sr", devInSr, 1'h1);
    srReq = 1'h0;
    do_init();
    close_out();
  end
  // cut a hang short
  initial begin
    repeat (4000) @(posedge clk);
    n_errors++;
    $display("MISMATCH t=%0t watchdog", $time);
    close_out();
  end
endmodule // sdrs_init_selfrefresh_seq_bench
`default_nettype wire
